// *** rtl/route_pkg.sv ***
// Overview of operation
// - Rate codes 0110/0111/1000 lock converter to generator one base, twice, four times.
// - Rate code 1001 gives half generator one base; 1011 gives one quarter.
// - Rate code 1010 gives generator two divided by three; 1100 by six.
// - Twenty-four route registers at consecutive indexes 0xF180 to 0xF197.
// - Route register n drives output channels 2n and 2n+1.
// - Registers 0 to 7 feed channels 0 to 15 on lane zero.
// - Registers 8 to 15 feed channels 16 to 31 on lane one.
// - Registers 16 to 19 feed channels 32 to 39 on lane two.
// - Registers 20 to 23 feed channels 40 to 47 on lane three.
// - Source code 000 leaves the pair disabled.
// - Source code 001 copies same-numbered serial input channels.
// - Source code 010 copies same-numbered DSP core output channels.
// - Source code 011 routes the converter picked by bits 5 to 3.
// - Converter pick k selects converter channels 2k and 2k+1.
// - Source code 100 takes microphone channels 0 and 1.
// - Source code 101 takes microphone channels 2 and 3.
// - All route registers reset to zero.
// - Rate code 0000 none; 0001-0100 follow lanes; 0101 follows DSP core.
package route_pkg;

    // ==========================================================
    // Register map (word indexes; byte address is four times)
    localparam logic [15:0] ROUTE_BASE_IDX = 16'hF180;
    localparam logic [15:0] ROUTE_LAST_IDX = 16'hF197;
    localparam logic [15:0] RATE_BASE_IDX = 16'hF140;
    localparam int ROUTE_REGS = 24;
    localparam int RATE_REGS = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ==========================================================
    // Route and rate register fields
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 2;
    localparam int PICK_LSB = 3;
    localparam int PICK_MSB = 5;
    localparam int RATE_LSB = 0;
    localparam int RATE_MSB = 3;

    // ==========================================================
    // Pair source codes
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_SERIAL = 3'h1;
    localparam logic [2:0] SRC_DSP = 3'h2;
    localparam logic [2:0] SRC_CONV = 3'h3;
    localparam logic [2:0] SRC_MIC_LO = 3'h4;
    localparam logic [2:0] SRC_MIC_HI = 3'h5;

    // ==========================================================
    // Converter target rate codes
    localparam logic [3:0] RATE_NONE = 4'h0;
    localparam logic [3:0] RATE_LANE0 = 4'h1;
    localparam logic [3:0] RATE_LANE1 = 4'h2;
    localparam logic [3:0] RATE_LANE2 = 4'h3;
    localparam logic [3:0] RATE_LANE3 = 4'h4;
    localparam logic [3:0] RATE_DSP = 4'h5;
    localparam logic [3:0] RATE_G1_X1 = 4'h6;
    localparam logic [3:0] RATE_G1_X2 = 4'h7;
    localparam logic [3:0] RATE_G1_X4 = 4'h8;
    localparam logic [3:0] RATE_G1_HALF = 4'h9;
    localparam logic [3:0] RATE_G2_THIRD = 4'hA;
    localparam logic [3:0] RATE_G1_QUARTER = 4'hB;
    localparam logic [3:0] RATE_G2_SIXTH = 4'hC;

    // ==========================================================
    // Bus answers and divider spans
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] G2_WRAP = 3'h5;
    localparam logic [2:0] G2_THIRD_A = 3'h2;

endpackage : route_pkg

// *** rtl/serial_output_source_router.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_output_source_router #(
    parameter int SAMPLE_W = 32,
    parameter int ADDR_W = 18
) (
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Audio sources
    input wire logic [48*SAMPLE_W-1:0] I_SERIAL_IN_DATA,
    input wire logic [48*SAMPLE_W-1:0] I_DSP_OUT_DATA,
    input wire logic [16*SAMPLE_W-1:0] I_CONV_OUT_DATA,
    input wire logic [4*SAMPLE_W-1:0] I_MIC_DATA,
    // Rate ticks
    input wire logic [3:0] I_LANE_RATE_TICK,
    input wire logic I_DSP_RATE_TICK,
    input wire logic I_GEN1_X4_TICK,
    input wire logic I_GEN2_TICK,
    // Routed lanes and converter rates
    output logic [16*SAMPLE_W-1:0] O_LANE0_DATA,
    output logic [16*SAMPLE_W-1:0] O_LANE1_DATA,
    output logic [8*SAMPLE_W-1:0] O_LANE2_DATA,
    output logic [8*SAMPLE_W-1:0] O_LANE3_DATA,
    output logic [23:0] O_PAIR_ACTIVE,
    output logic [7:0] O_CONV_RATE_TICK
);
    import route_pkg::*;

    // ==========================================================
    // Parameter check
    if (SAMPLE_W < 1 || ADDR_W < 18 || ADDR_W > 32) begin : g_bad_param
        $error("serial_output_source_router: unsupported SAMPLE_W or ADDR_W");
    end

    // Pair width
    localparam int PAIR_W = 2 * SAMPLE_W;

    // Decode an address to a register slot: {hit, is_rate, slot}
    function automatic logic [6:0] decode_slot(input logic [ADDR_W-1:0] addr);
        logic [15:0] idx;
        logic [15:0] route_off;
        logic [15:0] rate_off;
        // Word index
        idx = 16'(addr >> 2);
        // Window offsets
        route_off = idx - ROUTE_BASE_IDX;
        rate_off = idx - RATE_BASE_IDX;
        // Route, then rate
        decode_slot = 7'h00;
        if (idx >= ROUTE_BASE_IDX && idx <= ROUTE_LAST_IDX) begin
            decode_slot = {1'b1, 1'b0, route_off[4:0]};
        end else if (rate_off < 16'(RATE_REGS)) begin
            decode_slot = {1'b1, 1'b1, rate_off[4:0]};
        end
    endfunction : decode_slot

    // ==========================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_n;

    // Two flops
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ==========================================================
    // Write channel
    logic [15:0] route_reg [ROUTE_REGS];
    logic [15:0] rate_reg [RATE_REGS];

    // Handshake state
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic do_write;
    logic [6:0] wr_slot;

    // Write handshake
    assign O_AWREADY = !aw_held_reg && !bvalid_reg;
    assign O_WREADY = !w_held_reg && !bvalid_reg;
    assign O_BVALID = bvalid_reg;
    assign O_BRESP = bresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_slot = decode_slot(aw_addr_reg);

    // Address and data capture, either order
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else begin
            // Address
            if (I_AWVALID && O_AWREADY) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= I_AWADDR;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            // Data
            if (I_WVALID && O_WREADY) begin
                w_held_reg <= 1'b1;
                w_data_reg <= I_WDATA;
                w_strb_reg <= I_WSTRB;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            // Unmapped: error
            bresp_reg <= wr_slot[6] ? RESP_OKAY : RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Register storage, all sixteen bits kept
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            // Route regs
            for (int i = 0; i < ROUTE_REGS; i++) begin
                route_reg[i] <= REG_RESET;
            end
            // Rate regs
            for (int i = 0; i < RATE_REGS; i++) begin
                rate_reg[i] <= REG_RESET;
            end
        end else if (do_write && wr_slot[6]) begin
            // Low bytes only
            for (int b = 0; b < 2; b++) begin
                if (w_strb_reg[b]) begin
                    if (wr_slot[5]) begin
                        rate_reg[wr_slot[2:0]][b*8 +: 8] <= w_data_reg[b*8 +: 8];
                    end else begin
                        route_reg[wr_slot[4:0]][b*8 +: 8] <= w_data_reg[b*8 +: 8];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Read channel
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [6:0] rd_slot;

    // Read handshake
    assign O_ARREADY = !rvalid_reg;
    assign O_RVALID = rvalid_reg;
    assign O_RDATA = rdata_reg;
    assign O_RRESP = rresp_reg;
    assign rd_slot = decode_slot(I_ARADDR);

    // One-cycle read answer
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            rvalid_reg <= 1'b1;
            // Unmapped: error
            if (!rd_slot[6]) begin
                rdata_reg <= 32'h00000000;
                rresp_reg <= RESP_SLVERR;
            end else if (rd_slot[5]) begin
                rdata_reg <= {16'h0000, rate_reg[rd_slot[2:0]]};
                rresp_reg <= RESP_OKAY;
            end else begin
                rdata_reg <= {16'h0000, route_reg[rd_slot[4:0]]};
                rresp_reg <= RESP_OKAY;
            end
        end else if (I_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Pair routing
    logic [PAIR_W-1:0] pair_out_reg [ROUTE_REGS];
    logic [23:0] pair_on_reg;

    for (genvar p = 0; p < ROUTE_REGS; p++) begin : g_pair
        // Pair select
        logic [PAIR_W-1:0] pick;
        logic on;
        logic [2:0] conv_k;

        // Pick field
        assign conv_k = route_reg[p][PICK_MSB:PICK_LSB];

        // Source select; only bits 5 to 0 are looked at
        always_comb begin
            pick = '0;
            on = 1'b0;
            case (route_reg[p][SRC_MSB:SRC_LSB])
                SRC_SERIAL: begin
                    pick = I_SERIAL_IN_DATA[p*PAIR_W +: PAIR_W];
                    on = 1'b1;
                end
                SRC_DSP: begin
                    pick = I_DSP_OUT_DATA[p*PAIR_W +: PAIR_W];
                    on = 1'b1;
                end
                SRC_CONV: begin
                    pick = I_CONV_OUT_DATA[int'(conv_k)*PAIR_W +: PAIR_W];
                    on = 1'b1;
                end
                SRC_MIC_LO: begin
                    pick = I_MIC_DATA[0 +: PAIR_W];
                    on = 1'b1;
                end
                SRC_MIC_HI: begin
                    pick = I_MIC_DATA[PAIR_W +: PAIR_W];
                    on = 1'b1;
                end
                default: begin
                    pick = '0;
                    on = 1'b0;
                end
            endcase
        end

        // Registered pair sample
        always_ff @(posedge I_CLOCK or negedge rst_n) begin
            if (!rst_n) begin
                pair_out_reg[p] <= '0;
                pair_on_reg[p] <= 1'b0;
            end else begin
                pair_out_reg[p] <= pick;
                pair_on_reg[p] <= on;
            end
        end

        // Lane placement
        if (p < 8) begin : g_l0
            assign O_LANE0_DATA[p*PAIR_W +: PAIR_W] = pair_out_reg[p];
        end else if (p < 16) begin : g_l1
            assign O_LANE1_DATA[(p-8)*PAIR_W +: PAIR_W] = pair_out_reg[p];
        end else if (p < 20) begin : g_l2
            assign O_LANE2_DATA[(p-16)*PAIR_W +: PAIR_W] = pair_out_reg[p];
        end else begin : g_l3
            assign O_LANE3_DATA[(p-20)*PAIR_W +: PAIR_W] = pair_out_reg[p];
        end
    end

    // Active flags
    assign O_PAIR_ACTIVE = pair_on_reg;

    // ==========================================================
    // Internal rate dividers
    logic [3:0] g1_cnt_reg;
    logic [2:0] g2_cnt_reg;

    // Tick outputs
    logic t_g1_x4;
    logic t_g1_x2;
    logic t_g1_x1;
    logic t_g1_half;
    logic t_g1_quarter;
    logic t_g2_third;
    logic t_g2_sixth;

    // Generator one counts x4 ticks, generator two wraps at six
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            g1_cnt_reg <= 4'h0;
            g2_cnt_reg <= 3'h0;
        end else begin
            if (I_GEN1_X4_TICK) begin
                g1_cnt_reg <= g1_cnt_reg + 4'h1;
            end
            if (I_GEN2_TICK) begin
                g2_cnt_reg <= (g2_cnt_reg == G2_WRAP) ? 3'h0 : g2_cnt_reg + 3'h1;
            end
        end
    end

    // Divided tick pulses
    assign t_g1_x4 = I_GEN1_X4_TICK;
    assign t_g1_x2 = I_GEN1_X4_TICK && (g1_cnt_reg[0] == 1'b1);
    assign t_g1_x1 = I_GEN1_X4_TICK && (g1_cnt_reg[1:0] == 2'h3);
    assign t_g1_half = I_GEN1_X4_TICK && (g1_cnt_reg[2:0] == 3'h7);
    assign t_g1_quarter = I_GEN1_X4_TICK && (g1_cnt_reg == 4'hF);
    assign t_g2_third = I_GEN2_TICK &&
        (g2_cnt_reg == G2_THIRD_A || g2_cnt_reg == G2_WRAP);
    assign t_g2_sixth = I_GEN2_TICK && (g2_cnt_reg == G2_WRAP);

    // ==========================================================
    // Converter rate selection
    logic [7:0] conv_tick_reg;

    for (genvar c = 0; c < RATE_REGS; c++) begin : g_rate
        logic tick;

        // Rate decode
        always_comb begin
            tick = 1'b0;
            case (rate_reg[c][RATE_MSB:RATE_LSB])
                RATE_LANE0: tick = I_LANE_RATE_TICK[0];
                RATE_LANE1: tick = I_LANE_RATE_TICK[1];
                RATE_LANE2: tick = I_LANE_RATE_TICK[2];
                RATE_LANE3: tick = I_LANE_RATE_TICK[3];
                RATE_DSP: tick = I_DSP_RATE_TICK;
                RATE_G1_X1: tick = t_g1_x1;
                RATE_G1_X2: tick = t_g1_x2;
                RATE_G1_X4: tick = t_g1_x4;
                RATE_G1_HALF: tick = t_g1_half;
                RATE_G2_THIRD: tick = t_g2_third;
                RATE_G1_QUARTER: tick = t_g1_quarter;
                RATE_G2_SIXTH: tick = t_g2_sixth;
                default: tick = 1'b0;
            endcase
        end

        // Registered rate pulse
        always_ff @(posedge I_CLOCK or negedge rst_n) begin
            if (!rst_n) begin
                conv_tick_reg[c] <= 1'b0;
            end else begin
                conv_tick_reg[c] <= tick;
            end
        end
    end

    // Rate pulses
    assign O_CONV_RATE_TICK = conv_tick_reg;

endmodule : serial_output_source_router
`default_nettype wire

// *** tb/audio_source_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Source side: fixed channel patterns and periodic rate ticks
module audio_source_model #(
    parameter int SAMPLE_W = 32
) (
    input wire logic i_clock,
    output logic [48*SAMPLE_W-1:0] o_serial,
    output logic [48*SAMPLE_W-1:0] o_dsp,
    output logic [16*SAMPLE_W-1:0] o_conv,
    output logic [4*SAMPLE_W-1:0] o_mic,
    output logic [3:0] o_lane_tick,
    output logic o_dsp_tick,
    output logic o_gen1_tick,
    output logic o_gen2_tick
);
    logic [4:0] phase_reg = 5'h00;
    // Source id in the top nibble, channel number below
    always_comb begin
        for (int c = 0; c < 48; c++) begin
            o_serial[c*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'(32'h1000_0000 | c);
            o_dsp[c*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'(32'h2000_0000 | c);
            if (c < 16) o_conv[c*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'(32'h3000_0000 | c);
            if (c < 4) o_mic[c*SAMPLE_W +: SAMPLE_W] = SAMPLE_W'(32'h4000_0000 | c);
        end
    end
    // Phase wraps at 24 so every tick period divides it
    always_ff @(posedge i_clock) begin
        phase_reg <= (phase_reg == 5'h17) ? 5'h00 : phase_reg + 5'h01;
    end
    // Tick periods per source; generator one and two ticks share period two, in opposite phases
    always_comb begin
        o_lane_tick[0] = (phase_reg % 4) == 0;
        o_lane_tick[1] = (phase_reg % 6) == 0;
        o_lane_tick[2] = (phase_reg % 8) == 0;
        o_lane_tick[3] = (phase_reg % 12) == 0;
        o_dsp_tick = (phase_reg % 3) == 0;
        o_gen1_tick = phase_reg[0];
        o_gen2_tick = !phase_reg[0];
    end
endmodule : audio_source_model
`default_nettype wire

// *** tb/serial_output_source_router_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker
module serial_output_source_router_chk #(
    parameter int SAMPLE_W = 32
) (
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic [3:0] I_LANE_RATE_TICK,
    input wire logic I_DSP_RATE_TICK,
    input wire logic I_GEN1_X4_TICK,
    input wire logic I_GEN2_TICK,
    input wire logic [16*SAMPLE_W-1:0] O_LANE0_DATA,
    input wire logic [16*SAMPLE_W-1:0] O_LANE1_DATA,
    input wire logic [8*SAMPLE_W-1:0] O_LANE2_DATA,
    input wire logic [8*SAMPLE_W-1:0] O_LANE3_DATA,
    input wire logic [23:0] O_PAIR_ACTIVE,
    input wire logic [7:0] O_CONV_RATE_TICK
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    logic [48*SAMPLE_W-1:0] all_ch;
    logic [23:0] pair_zero;
    // Channel c of all lanes at slice c
    assign all_ch = {O_LANE3_DATA, O_LANE2_DATA, O_LANE1_DATA, O_LANE0_DATA};
    // Pairs whose two channels are silent
    always_comb begin
        for (int n = 0; n < 24; n++) begin
            pair_zero[n] = all_ch[2*n*SAMPLE_W +: 2*SAMPLE_W] == '0;
        end
    end
    a_bvalid_holds: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response changed before taken");
    a_rvalid_holds: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data changed before taken");
    a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_read_blocks: assert property (O_ARREADY == !O_RVALID)
        else $error("read address ready wrong");
    a_write_blocks: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write taken while response pending");
    a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
        else $error("write response late");
    a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read response late");
    a_idle_pair_zero: assert property ((~O_PAIR_ACTIVE & ~pair_zero) == 24'h000000)
        else $error("disabled pair carries data");
    a_tick_cause: assert property (|O_CONV_RATE_TICK |->
        $past(|{I_LANE_RATE_TICK, I_DSP_RATE_TICK, I_GEN1_X4_TICK, I_GEN2_TICK}))
        else $error("rate pulse without source tick");
    c_write_done: cover property (O_BVALID && I_BREADY);
    c_read_done: cover property (O_RVALID && I_RREADY);
    c_pair_active: cover property (O_PAIR_ACTIVE != 24'h000000);
    c_rate_pulse: cover property (|O_CONV_RATE_TICK);
endmodule : serial_output_source_router_chk
bind serial_output_source_router serial_output_source_router_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .I_CLOCK, .I_ARST_N, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
    .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RVALID, .I_RREADY, .I_LANE_RATE_TICK, .I_DSP_RATE_TICK,
    .I_GEN1_X4_TICK, .I_GEN2_TICK, .O_LANE0_DATA, .O_LANE1_DATA, .O_LANE2_DATA, .O_LANE3_DATA,
    .O_PAIR_ACTIVE, .O_CONV_RATE_TICK);
`default_nettype wire

// *** tb/serial_output_source_router_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_output_source_router_test;
    import route_pkg::*;
    localparam int W = 32;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dt, g1, g2;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [48*W-1:0] ser, dsp;
    logic [16*W-1:0] conv, l0, l1;
    logic [8*W-1:0] l2, l3;
    logic [4*W-1:0] mic;
    logic [3:0] lt;
    logic [23:0] act;
    logic [7:0] rt;
    int err_total = 0;
    int comparisons = 0;
    int rate_exp [16] = '{0, 24, 16, 12, 8, 32, 12, 24, 48, 6, 16, 3, 8, 0, 0, 0};
    // ==========================================================
    // Block, sources and clock
    serial_output_source_router #(.SAMPLE_W(W), .ADDR_W(18)) u_dut (
        .I_CLOCK(clk), .I_ARST_N(arst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SERIAL_IN_DATA(ser),
        .I_DSP_OUT_DATA(dsp), .I_CONV_OUT_DATA(conv), .I_MIC_DATA(mic), .I_LANE_RATE_TICK(lt),
        .I_DSP_RATE_TICK(dt), .I_GEN1_X4_TICK(g1), .I_GEN2_TICK(g2), .O_LANE0_DATA(l0), .O_LANE1_DATA(l1),
        .O_LANE2_DATA(l2), .O_LANE3_DATA(l3), .O_PAIR_ACTIVE(act), .O_CONV_RATE_TICK(rt));
    audio_source_model #(.SAMPLE_W(W)) u_src (.i_clock(clk), .o_serial(ser), .o_dsp(dsp), .o_conv(conv),
        .o_mic(mic), .o_lane_tick(lt), .o_dsp_tick(dt), .o_gen1_tick(g1), .o_gen2_tick(g2));
    // Free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // Reporting and bus tasks
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic bus_timeout;
        err_total++;
        $display("unexpected at %0t: bus answer missing", $time);
        finish_test();
    endtask : bus_timeout
    task automatic bus_write(input logic [17:0] a, input logic [15:0] d, input logic [1:0] er);
        logic aw = 1'b1;
        logic w = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bready <= 1'b0;
                check(32'(bresp), 32'(er), "write response");
                return;
            end
        end
        bus_timeout();
    endtask : bus_write
    task automatic bus_read(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar = 1'b1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rready <= 1'b0;
                check(rdata, ed, "read data");
                check(32'(rresp), 32'(er), "read response");
                return;
            end
        end
        bus_timeout();
    endtask : bus_read
    function automatic logic [17:0] route_addr(input int n);
        return 18'h3C600 + 18'(4 * n);
    endfunction : route_addr
    function automatic logic [31:0] pair_exp(input logic [15:0] r, input int c);
        case (r[2:0])
            SRC_SERIAL: return 32'h1000_0000 | c;
            SRC_DSP: return 32'h2000_0000 | c;
            SRC_CONV: return 32'h3000_0000 | (2 * r[5:3] + c % 2);
            SRC_MIC_LO: return 32'h4000_0000 | (c % 2);
            SRC_MIC_HI: return 32'h4000_0000 | (2 + c % 2);
            default: return 32'h0000_0000;
        endcase
    endfunction : pair_exp
    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        for (int n = 0; n < ROUTE_REGS; n++) bus_read(route_addr(n), 32'h0000_0000, RESP_OKAY);
        check(32'(act), 32'h0000_0000, "pair active");
    endtask : t_reset_values
    task automatic t_all_pairs;
        logic [15:0] r [24];
        logic [48*W-1:0] all;
        for (int n = 0; n < 24; n++) begin
            r[n] = {10'(16'h02A0 + n), 3'(n / 3), 3'(n % 8)};
            bus_write(route_addr(n), r[n], RESP_OKAY);
        end
        repeat (3) @(posedge clk);
        all = {l3, l2, l1, l0};
        for (int c = 0; c < 48; c++) check(all[c*W +: W], pair_exp(r[c/2], c), "channel");
        for (int n = 0; n < 24; n++) check(32'(act[n]), 32'(r[n][2:0] inside {[1:5]}), "active");
        for (int n = 0; n < 24; n++) bus_read(route_addr(n), {16'h0000, r[n]}, RESP_OKAY);
    endtask : t_all_pairs
    task automatic t_pick_all;
        for (int k = 0; k < 8; k++) begin
            bus_write(route_addr(5), {10'h000, 3'(k), SRC_CONV}, RESP_OKAY);
            repeat (3) @(posedge clk);
            check(l0[10*W +: W], 32'h3000_0000 | (2 * k), "pick low");
            check(l0[11*W +: W], 32'h3000_0000 | (2 * k + 1), "pick high");
        end
        bus_write(route_addr(5), {10'h000, 3'h7, SRC_SERIAL}, RESP_OKAY);
        repeat (3) @(posedge clk);
        check(l0[10*W +: W], 32'h1000_000A, "pick ignored");
    endtask : t_pick_all
    task automatic t_unmapped;
        bus_write(route_addr(24), 16'hFFFF, RESP_SLVERR);
        bus_read(route_addr(24), 32'h0000_0000, RESP_SLVERR);
        bus_read(18'h3C5FC, 32'h0000_0000, RESP_SLVERR);
        bus_read(route_addr(5), {16'h0000, 10'h000, 3'h7, SRC_SERIAL}, RESP_OKAY);
    endtask : t_unmapped
    task automatic t_rates;
        int cnt;
        for (int code = 0; code < 16; code++) begin
            cnt = 0;
            bus_write(18'h3C500 + 18'(4 * (code % 8)), 16'(code), RESP_OKAY);
            repeat (4) @(posedge clk);
            repeat (96) begin
                @(posedge clk);
                cnt += (rt[code % 8] === 1'b1) ? 1 : 0;
            end
            check(32'(cnt), 32'(rate_exp[code]), "rate pulses");
        end
    endtask : t_rates
    // Reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_values();
        t_all_pairs();
        t_pick_all();
        t_unmapped();
        t_rates();
        finish_test();
    end
endmodule : serial_output_source_router_test
`default_nettype wire
